/* File: hw/clk_out_consts.svh */
`ifndef CLK_OUT_CONSTS_SVH
`define CLK_OUT_CONSTS_SVH

// Register offsets
`define OFS_SYNTH_MULT_LO      7'h38
`define OFS_SYNTH_MULT_HI      7'h39
`define OFS_FP_RATE            7'h3e
`define OFS_FP_SHAPE           7'h3f
`define OFS_ETH_SYNTH_CTL      7'h51
`define OFS_SE_RATE_SEL        7'h52
`define OFS_BAL_RATE_SEL       7'h61

// Reset values
`define RST_SYNTH_MULT_LO      8'h00
`define RST_SYNTH_MULT_HI      8'h00
`define RST_FP_RATE            8'h00
`define RST_FP_SHAPE           8'h00
`define RST_ETH_SYNTH_CTL      8'h00
`define RST_SE_RATE_SEL        8'h04
`define RST_BAL_RATE_SEL       8'h00

// Field positions
`define BIT_ETH_EN             0
`define BIT_SE_GROUP           1
`define BIT_BAL_GROUP          2
`define BIT_FP_STYLE_CLK       3
`define BIT_FP_ALIGN_FALL      4
`define BIT_FP_POL_NEG         5

// Timing
`define SYS_CLK_HZ             40000000
`define SYS_PERIOD_PS          25000
`define FP_NCO_MOD             (3 * `SYS_CLK_HZ)
`define PCLK_EDGE_HZ_PER_N     16000
`define PCLK_EDGE_HZ_N0        4000
`define PCLK_MAX_N             12500
`define FP_W0_PS               244141
`define FP_W1_PS               122070
`define FP_W2_PS               61035
`define FP_W3_PS               30518
`define FP_W4_PS               15259
`define CYC_UP(ps)             (((ps) + `SYS_PERIOD_PS - 1) / `SYS_PERIOD_PS)

`endif

/* File: hw/clk_out_pkg.sv */
package clk_out_pkg;

    typedef struct packed {
        logic [7:0] mult_lo;
        logic [7:0] mult_hi;
        logic [7:0] fp_rate;
        logic [7:0] fp_shape;
        logic [7:0] synth_ctl;
        logic [7:0] se_sel;
        logic [7:0] bal_sel;
    } regs_t;

    typedef struct packed {
        logic        eth_en;
        logic        se_group;
        logic        bal_group;
        logic [3:0]  se_code;
        logic [2:0]  bal_code;
    } rate_sel_t;

    typedef struct packed {
        logic [19:0] khz;
        logic        reserved;
    } rate_t;

    typedef struct packed {
        regs_t       regs;
        logic [7:0]  rdata;
        logic        pclk;
        logic        fp_pending;
        logic        fp_active;
        logic        fp_level;
        logic [3:0]  width_cnt;
        logic [1:0]  edge_cnt;
        logic        fp_out;
        rate_t       se_rate;
        rate_t       bal_rate;
        logic [19:0] prog_khz;
        logic        prog_over;
    } state_t;

endpackage

/* File: hw/nco_tick.sv */
module nco_tick #(
    parameter int          W   = 32,
    parameter logic [31:0] MOD = 32'd40000000
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] inc,
    output logic              tick
);
    logic [W-1:0] acc_q;
    logic [W-1:0] acc_d;
    logic [W-1:0] sum;

    always_comb begin
        sum   = acc_q + inc;
        acc_d = sum;
        tick  = 1'b0;
        if (inc >= W'(MOD)) begin
            acc_d = acc_q;
            tick  = 1'b1;
        end else if (sum >= W'(MOD)) begin
            acc_d = sum - W'(MOD);
            tick  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end
endmodule

/* File: hw/rate_table.sv */
module rate_table (
    input  wire clk_out_pkg::rate_sel_t sel,
    output clk_out_pkg::rate_t          se_rate,
    output clk_out_pkg::rate_t          bal_rate
);
    always_comb begin
        se_rate = '{khz: 20'h0, reserved: 1'b1};
        if (!sel.eth_en && !sel.se_group) begin
            case (sel.se_code)
                4'h2: se_rate = '{khz: 20'd77760, reserved: 1'b0};
                4'h3: se_rate = '{khz: 20'd38880, reserved: 1'b0};
                4'h4: se_rate = '{khz: 20'd19440, reserved: 1'b0};
                4'h5: se_rate = '{khz: 20'd9720,  reserved: 1'b0};
                4'ha: se_rate = '{khz: 20'd51840, reserved: 1'b0};
                4'hb: se_rate = '{khz: 20'd25920, reserved: 1'b0};
                4'hc: se_rate = '{khz: 20'd12960, reserved: 1'b0};
                4'hd: se_rate = '{khz: 20'd6480,  reserved: 1'b0};
                default: se_rate = '{khz: 20'h0, reserved: 1'b1};
            endcase
        end else if (sel.eth_en && sel.se_group) begin
            case (sel.se_code)
                4'h1: se_rate = '{khz: 20'd125000, reserved: 1'b0};
                4'h2: se_rate = '{khz: 20'd62500,  reserved: 1'b0};
                4'h5: se_rate = '{khz: 20'd50000,  reserved: 1'b0};
                4'h6: se_rate = '{khz: 20'd25000,  reserved: 1'b0};
                4'h7: se_rate = '{khz: 20'd12500,  reserved: 1'b0};
                default: se_rate = '{khz: 20'h0, reserved: 1'b1};
            endcase
        end
    end

    always_comb begin
        bal_rate = '{khz: 20'h0, reserved: 1'b1};
        if (!sel.eth_en && !sel.bal_group) begin
            case (sel.bal_code)
                3'h0: bal_rate = '{khz: 20'd19440,  reserved: 1'b0};
                3'h1: bal_rate = '{khz: 20'd38880,  reserved: 1'b0};
                3'h2: bal_rate = '{khz: 20'd77760,  reserved: 1'b0};
                3'h3: bal_rate = '{khz: 20'd155520, reserved: 1'b0};
                3'h4: bal_rate = '{khz: 20'd311040, reserved: 1'b0};
                3'h5: bal_rate = '{khz: 20'd622080, reserved: 1'b0};
                3'h6: bal_rate = '{khz: 20'd6480,   reserved: 1'b0};
                default: bal_rate = '{khz: 20'd51840, reserved: 1'b0};
            endcase
        end else if (sel.eth_en && sel.bal_group) begin
            case (sel.bal_code)
                3'h1: bal_rate = '{khz: 20'd125000, reserved: 1'b0};
                3'h2: bal_rate = '{khz: 20'd62500,  reserved: 1'b0};
                3'h5: bal_rate = '{khz: 20'd50000,  reserved: 1'b0};
                3'h6: bal_rate = '{khz: 20'd25000,  reserved: 1'b0};
                3'h7: bal_rate = '{khz: 20'd12500,  reserved: 1'b0};
                default: bal_rate = '{khz: 20'h0, reserved: 1'b1};
            endcase
        end else if (sel.eth_en && !sel.bal_group) begin
            case (sel.bal_code)
                3'h3: bal_rate = '{khz: 20'd156250, reserved: 1'b0};
                3'h4: bal_rate = '{khz: 20'd312500, reserved: 1'b0};
                default: bal_rate = '{khz: 20'h0, reserved: 1'b1};
            endcase
        end
    end
endmodule

/* File: hw/output_clock_frame_pulse_select.sv */
`include "clk_out_consts.svh"

module output_clock_frame_pulse_select (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [6:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic      [19:0] se_rate_khz,
    output logic             se_rate_reserved,
    output logic      [19:0] bal_rate_khz,
    output logic             bal_rate_reserved,
    output logic      [19:0] prog_rate_khz,
    output logic             prog_rate_over,
    output logic             prog_clk,
    output logic             frame_pulse_output
);
    ////////////////////////////////////////////////////////////////////////////
    // State and sub-blocks

    clk_out_pkg::state_t    st_q;
    clk_out_pkg::state_t    st_d;
    clk_out_pkg::rate_sel_t rate_sel;
    clk_out_pkg::rate_t     se_rate;
    clk_out_pkg::rate_t     bal_rate;
    logic [15:0]            mult_n;
    logic [31:0]            pclk_inc;
    logic [31:0]            fp_inc;
    logic                   pclk_tick;
    logic                   fp_tick;
    logic                   rise_evt;
    logic                   fall_evt;
    logic                   align_evt;
    logic [2:0]             width_code;
    logic                   style_clk;
    logic                   align_fall;
    logic                   pol_neg;
    logic [3:0]             fixed_cycles;

    assign mult_n     = {st_q.regs.mult_hi, st_q.regs.mult_lo};
    assign width_code = st_q.regs.fp_shape[2:0];
    assign style_clk  = st_q.regs.fp_shape[`BIT_FP_STYLE_CLK];
    assign align_fall = st_q.regs.fp_shape[`BIT_FP_ALIGN_FALL];
    assign pol_neg    = st_q.regs.fp_shape[`BIT_FP_POL_NEG];

    always_comb begin
        rate_sel.eth_en    = st_q.regs.synth_ctl[`BIT_ETH_EN];
        rate_sel.se_group  = st_q.regs.synth_ctl[`BIT_SE_GROUP];
        rate_sel.bal_group = st_q.regs.synth_ctl[`BIT_BAL_GROUP];
        rate_sel.se_code   = st_q.regs.se_sel[3:0];
        rate_sel.bal_code  = st_q.regs.bal_sel[2:0];
    end

    rate_table u_rate_table (
        .sel      (rate_sel),
        .se_rate  (se_rate),
        .bal_rate (bal_rate)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Programmable clock: edge rate is twice the output rate

    always_comb begin
        if (mult_n == 16'h0) begin
            pclk_inc = 32'(`PCLK_EDGE_HZ_N0);
        end else begin
            pclk_inc = 32'(mult_n) * 32'(`PCLK_EDGE_HZ_PER_N);
        end
    end

    nco_tick #(
        .W   (32),
        .MOD (32'(`SYS_CLK_HZ))
    ) u_pclk_nco (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .inc     (pclk_inc),
        .tick    (pclk_tick)
    );

    assign rise_evt  = pclk_tick && !st_q.pclk;
    assign fall_evt  = pclk_tick && st_q.pclk;
    assign align_evt = align_fall ? fall_evt : rise_evt;

    ////////////////////////////////////////////////////////////////////////////
    // Frame rate: accumulator counts in thirds of a hertz

    always_comb begin
        case (st_q.regs.fp_rate[3:0])
            4'h0:    fp_inc = 32'd500;
            4'h1:    fp_inc = 32'd1200;
            4'h2:    fp_inc = 32'd3000;
            4'h3:    fp_inc = 32'd6000;
            4'h4:    fp_inc = 32'd12000;
            4'h5:    fp_inc = 32'd24000;
            4'h6:    fp_inc = 32'd96000;
            4'h7:    fp_inc = 32'd192000;
            4'h8:    fp_inc = 32'd3;
            default: fp_inc = 32'd0;
        endcase
        if (style_clk) begin
            fp_inc = {fp_inc[30:0], 1'b0};
        end
    end

    nco_tick #(
        .W   (32),
        .MOD (32'(`FP_NCO_MOD))
    ) u_fp_nco (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .inc     (fp_inc),
        .tick    (fp_tick)
    );

    always_comb begin
        case (width_code)
            3'h0:    fixed_cycles = 4'(`CYC_UP(`FP_W0_PS));
            3'h1:    fixed_cycles = 4'(`CYC_UP(`FP_W1_PS));
            3'h2:    fixed_cycles = 4'(`CYC_UP(`FP_W2_PS));
            3'h3:    fixed_cycles = 4'(`CYC_UP(`FP_W3_PS));
            3'h4:    fixed_cycles = 4'(`CYC_UP(`FP_W4_PS));
            default: fixed_cycles = 4'h1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_d = st_q;

        // Register writes
        if (reg_wr) begin
            if (reg_addr == `OFS_SYNTH_MULT_LO) begin
                st_d.regs.mult_lo = reg_wdata;
            end else if (reg_addr == `OFS_SYNTH_MULT_HI) begin
                st_d.regs.mult_hi = reg_wdata;
            end else if (reg_addr == `OFS_FP_RATE) begin
                st_d.regs.fp_rate = reg_wdata;
            end else if (reg_addr == `OFS_FP_SHAPE) begin
                st_d.regs.fp_shape = reg_wdata;
            end else if (reg_addr == `OFS_ETH_SYNTH_CTL) begin
                st_d.regs.synth_ctl = reg_wdata;
            end else if (reg_addr == `OFS_SE_RATE_SEL) begin
                st_d.regs.se_sel = reg_wdata;
            end else if (reg_addr == `OFS_BAL_RATE_SEL) begin
                st_d.regs.bal_sel = reg_wdata;
            end
        end

        // Register reads, unmapped offsets answer zero
        if (reg_rd) begin
            if (reg_addr == `OFS_SYNTH_MULT_LO) begin
                st_d.rdata = st_q.regs.mult_lo;
            end else if (reg_addr == `OFS_SYNTH_MULT_HI) begin
                st_d.rdata = st_q.regs.mult_hi;
            end else if (reg_addr == `OFS_FP_RATE) begin
                st_d.rdata = st_q.regs.fp_rate;
            end else if (reg_addr == `OFS_FP_SHAPE) begin
                st_d.rdata = st_q.regs.fp_shape;
            end else if (reg_addr == `OFS_ETH_SYNTH_CTL) begin
                st_d.rdata = st_q.regs.synth_ctl;
            end else if (reg_addr == `OFS_SE_RATE_SEL) begin
                st_d.rdata = st_q.regs.se_sel;
            end else if (reg_addr == `OFS_BAL_RATE_SEL) begin
                st_d.rdata = st_q.regs.bal_sel;
            end else begin
                st_d.rdata = 8'h00;
            end
        end

        // Rate reports
        st_d.se_rate  = se_rate;
        st_d.bal_rate = bal_rate;
        if (mult_n == 16'h0) begin
            st_d.prog_khz = 20'd2;
        end else begin
            st_d.prog_khz = {1'b0, mult_n, 3'b000};
        end
        st_d.prog_over = (mult_n > 16'(`PCLK_MAX_N));

        // Programmable clock
        if (pclk_tick) begin
            st_d.pclk = !st_q.pclk;
        end

        // Frame pulse: a rate tick waits for the chosen clock edge
        if (fp_tick) begin
            st_d.fp_pending = 1'b1;
        end
        if (st_q.fp_pending && align_evt) begin
            st_d.fp_pending = fp_tick;
            if (style_clk) begin
                st_d.fp_level = !st_q.fp_level;
            end else begin
                st_d.fp_active = 1'b1;
                st_d.width_cnt = fixed_cycles - 4'h1;
                st_d.edge_cnt  = 2'd0;
            end
        end else if (st_q.fp_active) begin
            if (width_code == 3'h7) begin
                if (pclk_tick) begin
                    st_d.edge_cnt = st_q.edge_cnt + 2'd1;
                    if (st_q.edge_cnt == 2'd1) begin
                        st_d.fp_active = 1'b0;
                    end
                end
            end else if (st_q.width_cnt == 4'h0) begin
                st_d.fp_active = 1'b0;
            end else begin
                st_d.width_cnt = st_q.width_cnt - 4'h1;
            end
        end
        if (style_clk) begin
            st_d.fp_active = 1'b0;
            st_d.fp_out    = st_d.fp_level ^ pol_neg;
        end else begin
            st_d.fp_out    = st_d.fp_active ^ pol_neg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q                <= '0;
            st_q.regs.mult_lo   <= `RST_SYNTH_MULT_LO;
            st_q.regs.mult_hi   <= `RST_SYNTH_MULT_HI;
            st_q.regs.fp_rate   <= `RST_FP_RATE;
            st_q.regs.fp_shape  <= `RST_FP_SHAPE;
            st_q.regs.synth_ctl <= `RST_ETH_SYNTH_CTL;
            st_q.regs.se_sel    <= `RST_SE_RATE_SEL;
            st_q.regs.bal_sel   <= `RST_BAL_RATE_SEL;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata          = st_q.rdata;
    assign se_rate_khz        = st_q.se_rate.khz;
    assign se_rate_reserved   = st_q.se_rate.reserved;
    assign bal_rate_khz       = st_q.bal_rate.khz;
    assign bal_rate_reserved  = st_q.bal_rate.reserved;
    assign prog_rate_khz      = st_q.prog_khz;
    assign prog_rate_over     = st_q.prog_over;
    assign prog_clk           = st_q.pclk;
    assign frame_pulse_output = st_q.fp_out;
endmodule

/* File: tb/clk_out_sva.sv */
module clk_out_sva (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [6:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic [19:0] se_rate_khz,
    input wire logic        se_rate_reserved,
    input wire logic [19:0] bal_rate_khz,
    input wire logic        bal_rate_reserved,
    input wire logic [19:0] prog_rate_khz,
    input wire logic        prog_rate_over,
    input wire logic        prog_clk,
    input wire logic        frame_pulse_output
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the control registers except the frame rate register, and settle counter
    logic [15:0] n_q;
    logic [7:0]  ctl_q;
    logic [7:0]  se_q;
    logic [7:0]  bal_q;
    logic [7:0]  shp_q;
    logic [1:0]  quiet_q;
    logic        ok;
    logic        fp;
    assign ok = quiet_q[1];
    assign fp = frame_pulse_output;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            n_q     <= 16'h0000;
            ctl_q   <= 8'h00;
            se_q    <= 8'h04;
            bal_q   <= 8'h00;
            shp_q   <= 8'h00;
            quiet_q <= 2'h0;
        end else if (reg_wr) begin
            quiet_q <= 2'h0;
            case (reg_addr)
                7'h38: n_q[7:0]  <= reg_wdata;
                7'h39: n_q[15:8] <= reg_wdata;
                7'h3f: shp_q     <= reg_wdata;
                7'h51: ctl_q     <= reg_wdata;
                7'h52: se_q      <= reg_wdata;
                7'h61: bal_q     <= reg_wdata;
                default: ;
            endcase
        end else if (quiet_q != 2'h3) begin
            quiet_q <= quiet_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Rate decode
    property p_se_tel;
        ok && ctl_q[1:0] == 2'h0 && se_q[3:0] == 4'h2 |-> se_rate_khz == 20'h12fc0;
    endproperty
    a_se_tel: assert property (p_se_tel) else $error("single-ended telecom rate wrong");
    property p_se_eth;
        ok && ctl_q[1:0] == 2'h3 && se_q[3:0] == 4'h1 |-> se_rate_khz == 20'h1e848;
    endproperty
    a_se_eth: assert property (p_se_eth) else $error("single-ended ethernet rate wrong");
    property p_se_mix;
        ok && ctl_q[1:0] == 2'h1 |-> se_rate_reserved;
    endproperty
    a_se_mix: assert property (p_se_mix) else $error("mixed mode not flagged");
    property p_bal_tel;
        ok && !ctl_q[0] && !ctl_q[2] && bal_q[2:0] == 3'h5 |-> bal_rate_khz == 20'h97e00;
    endproperty
    a_bal_tel: assert property (p_bal_tel) else $error("balanced telecom rate wrong");
    property p_bal_low;
        ok && ctl_q[0] && ctl_q[2] && bal_q[2:0] == 3'h6
            |-> bal_rate_khz == 20'h061a8 && !bal_rate_reserved;
    endproperty
    a_bal_low: assert property (p_bal_low) else $error("balanced low rate wrong");
    property p_bal_high;
        ok && ctl_q[0] && !ctl_q[2] && bal_q[2:0] == 3'h4 |-> bal_rate_khz == 20'h4c4b4;
    endproperty
    a_bal_high: assert property (p_bal_high) else $error("balanced high rate wrong");
    property p_prog;
        ok |-> prog_rate_khz == ((n_q == 16'h0000) ? 20'h00002 : {1'b0, n_q, 3'h0});
    endproperty
    a_prog: assert property (p_prog) else $error("programmable rate wrong");
    property p_over;
        ok |-> prog_rate_over == (n_q > 16'h30d4);
    endproperty
    a_over: assert property (p_over) else $error("over-range flag wrong");
    property p_pclk;
        ok && n_q == 16'h007d && $changed(prog_clk)
            |=> $stable(prog_clk) [*8] ##12 $changed(prog_clk);
    endproperty
    a_pclk: assert property (p_pclk) else $error("programmable clock half period wrong");

    ////////////////////////////////////////////////////////////////////////////////
    // Frame pulse shape
    property p_w4;
        ok && $rose(fp) && shp_q == 8'h04 |=> !fp;
    endproperty
    a_w4: assert property (p_w4) else $error("shortest pulse too long");
    property p_w1;
        ok && $rose(fp) && shp_q == 8'h01 |-> fp [*5] ##1 !fp;
    endproperty
    a_w1: assert property (p_w1) else $error("pulse width code 1 wrong");
    property p_neg;
        ok && $fell(fp) && shp_q == 8'h24 |=> fp;
    endproperty
    a_neg: assert property (p_neg) else $error("negative pulse wrong");

    c_pulse: cover property ($rose(fp));
    c_over: cover property (prog_rate_over);
    c_res: cover property (se_rate_reserved);
    c_pclk: cover property (ok && n_q == 16'h007d && $changed(prog_clk));
endmodule

bind output_clock_frame_pulse_select clk_out_sva clk_out_sva_inst (
    .clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .se_rate_khz, .se_rate_reserved, .bal_rate_khz, .bal_rate_reserved,
    .prog_rate_khz, .prog_rate_over, .prog_clk, .frame_pulse_output
);

/* File: tb/frame_sink.sv */
module frame_sink (
    input  wire logic clk_sys,
    input  wire logic fp,
    input  wire logic neg,
    output int        width_seen,
    output int        period_seen,
    output int        pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    int   run;
    int   since;
    logic act;
    logic act_q;
    assign act = fp ^ neg;
    initial begin
        width_seen = 0;
        period_seen = 0;
        pulses = 0;
        run = 0;
        since = 0;
        act_q = 1'b0;
    end
    // Measures active run length and start-to-start spacing in system cycles
    always @(posedge clk_sys) begin
        act_q <= act;
        since <= (act && !act_q) ? 1 : since + 1;
        run <= (act && !act_q) ? 1 : run + 32'(act);
        if (act && !act_q) begin
            period_seen <= since;
        end
        if (!act && act_q) begin
            width_seen <= run;
            pulses <= pulses + 1;
        end
    end
endmodule

/* File: tb/output_clock_frame_pulse_select_tb_top.sv */
module output_clock_frame_pulse_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys;
    logic        rst_n;
    logic [6:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [19:0] se_rate_khz;
    logic        se_rate_reserved;
    logic [19:0] bal_rate_khz;
    logic        bal_rate_reserved;
    logic [19:0] prog_rate_khz;
    logic        prog_rate_over;
    logic        prog_clk;
    logic        frame_pulse_output;
    logic        neg;
    int          width_seen;
    int          period_seen;
    int          pulses;
    int          mismatches;
    int          checked;
    logic [6:0]  offs [7] = '{7'h38, 7'h39, 7'h3e, 7'h3f, 7'h51, 7'h52, 7'h61};

    output_clock_frame_pulse_select output_clock_frame_pulse_select_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .se_rate_khz(se_rate_khz), .se_rate_reserved(se_rate_reserved),
        .bal_rate_khz(bal_rate_khz), .bal_rate_reserved(bal_rate_reserved),
        .prog_rate_khz(prog_rate_khz), .prog_rate_over(prog_rate_over),
        .prog_clk(prog_clk), .frame_pulse_output(frame_pulse_output)
    );
    frame_sink frame_sink_inst (
        .clk_sys(clk_sys), .fp(frame_pulse_output), .neg(neg),
        .width_seen(width_seen), .period_seen(period_seen), .pulses(pulses)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic final_report();
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rng(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, lo);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        cmp({12'h000, reg_rdata}, {12'h000, exp});
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic rates(input logic [7:0] ctl, input logic [3:0] se, input logic [2:0] bal,
                         input logic [19:0] se_k, input logic [19:0] bal_k,
                         input logic [1:0] res);
        wr(7'h51, ctl);
        wr(7'h52, {4'h0, se});
        wr(7'h61, {5'h00, bal});
        settle();
        cmp(se_rate_khz, se_k);
        cmp({18'h00000, se_rate_reserved, bal_rate_reserved}, {18'h00000, res});
        if (!res[0]) begin
            cmp(bal_rate_khz, bal_k);
        end
    endtask
    task automatic prog(input logic [15:0] n, input logic [19:0] k, input logic ov);
        wr(7'h38, n[7:0]);
        wr(7'h39, n[15:8]);
        settle();
        cmp(prog_rate_khz, k);
        cmp({19'h00000, prog_rate_over}, {19'h00000, ov});
    endtask
    task automatic frame(input logic [7:0] shape, input logic [7:0] rate,
                         input int wlo, input int whi, input int plo, input int phi);
        int start;
        wr(7'h3e, rate);
        wr(7'h3f, shape);
        neg <= shape[5];
        start = pulses;
        for (int i = 0; i < 5000 && pulses < start + 3; i++) begin
            @(posedge clk_sys);
        end
        if (pulses < start + 3) begin
            mismatches++;
            final_report();
        end
        rng(width_seen, wlo, whi);
        rng(period_seen, plo, phi);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Stimulus
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        rst_n = 1'b0;
        reg_addr = 7'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        neg = 1'b0;
        mismatches = 0;
        checked = 0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(offs[i], (i == 5) ? 8'h04 : 8'h00);
        end
        cmp(se_rate_khz, 20'h04bf0);
        cmp(bal_rate_khz, 20'h04bf0);
        cmp(prog_rate_khz, 20'h00002);
        for (int i = 0; i < 7; i++) begin
            wr(offs[i], {1'b1, offs[i]});
            rd(offs[i], {1'b1, offs[i]});
        end
        wr(7'h40, 8'hff);
        rd(7'h40, 8'h00);
        rates(8'h00, 4'h2, 3'h3, 20'h12fc0, 20'h25f80, 2'h0);
        rates(8'h00, 4'h4, 3'h5, 20'h04bf0, 20'h97e00, 2'h0);
        rates(8'h00, 4'h1, 3'h0, 20'h00000, 20'h04bf0, 2'h2);
        rates(8'h07, 4'h1, 3'h1, 20'h1e848, 20'h1e848, 2'h0);
        rates(8'h07, 4'h2, 3'h2, 20'h0f424, 20'h0f424, 2'h0);
        rates(8'h07, 4'h5, 3'h5, 20'h0c350, 20'h0c350, 2'h0);
        rates(8'h07, 4'h6, 3'h6, 20'h061a8, 20'h061a8, 2'h0);
        rates(8'h07, 4'h7, 3'h7, 20'h030d4, 20'h030d4, 2'h0);
        rates(8'h03, 4'h6, 3'h3, 20'h061a8, 20'h2625a, 2'h0);
        rates(8'h03, 4'h7, 3'h4, 20'h030d4, 20'h4c4b4, 2'h0);
        rates(8'h01, 4'h2, 3'h3, 20'h00000, 20'h2625a, 2'h2);
        prog(16'h0000, 20'h00002, 1'b0);
        prog(16'h30d4, 20'h186a0, 1'b0);
        prog(16'h30d5, 20'h186a8, 1'b1);
        prog(16'hffff, 20'h7fff8, 1'b1);
        prog(16'h0100, 20'h00800, 1'b0);
        frame(8'h00, 8'h07, 10, 10, 600, 650);
        frame(8'h01, 8'h07, 5, 5, 600, 650);
        frame(8'h02, 8'h07, 3, 3, 600, 650);
        frame(8'h03, 8'h07, 2, 2, 600, 650);
        frame(8'h04, 8'h07, 1, 1, 600, 650);
        frame(8'h24, 8'h07, 1, 1, 600, 650);
        frame(8'h14, 8'h06, 1, 1, 1225, 1275);
        frame(8'h08, 8'h07, 290, 335, 600, 650);
        prog(16'h007d, 20'h003e8, 1'b0);
        frame(8'h07, 8'h07, 39, 41, 580, 670);
        final_report();
    end
endmodule
